// ==== src/fdais_sequencer.sv ====
// Flash erase, byte-program and indirect-read sequencer with boot upgrade.
// Assumes a flash array that returns read data in the same cycle as its
// address flop changes, and a CPU that stops while cpuClkHalt is high.
`timescale 1ns/100ps

module fdais_sequencer
#(
   parameter int MsCycles    = fdais_pkg::MS_CYCLES,
   parameter int ExtraCycles = fdais_pkg::EXTRA_CYCLES,
   parameter int InfoCycles  = fdais_pkg::INFO_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sfrWr,
   input  wire logic        sfrRd,
   input  wire logic [7:0]  sfrAddr,
   input  wire logic [7:0]  sfrWdata,
   output      logic [7:0]  sfrRdata,
   input  wire logic        xbusWr,
   input  wire logic        xbusRd,
   input  wire logic [7:0]  xbusAddr,
   input  wire logic [7:0]  xbusWdata,
   output      logic [7:0]  xbusRdata,
   input  wire logic [1:0]  bootSel,
   input  wire logic [15:0] codeAddr,
   output      logic [7:0]  codeRdata,
   input  wire logic [7:0]  flashRdata,
   output      logic [16:0] flashRdAddr,
   output      logic [16:0] flashOpAddr,
   output      logic [7:0]  flashOpData,
   output      logic        flashErase,
   output      logic        flashProg,
   output      logic        cpuClkHalt,
   output      logic        upgradeMode
);
   import fdais_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]       addrHi;
      logic [7:0]       addrLo;
      logic [7:0]       wdata;
      logic [7:0]       cmd;
      logic [7:0]       tim;
      logic [7:0]       jump;
      logic             areaSel;
      logic             upgrade;
      logic             inBoot;
      logic [2:0]       enIdx;
      logic [2:0]       exIdx;
      logic [2:0]       appIdx;
      logic [2:0]       bootIdx;
      fdais_op_e        op;
      logic [CNT_W-1:0] cnt;
      logic [16:0]      opAddr;
      logic [7:0]       opData;
      logic [16:0]      rdAddr;
      logic [7:0]       rdData;
      logic [7:0]       codeData;
      logic [7:0]       sfrOut;
      logic [7:0]       xbusOut;
      logic [15:0]      offset;
      logic             erase;
      logic             prog;
      logic             halt;
   } fdais_state_s;

   fdais_state_s st;
   fdais_state_s next_st;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Byte n of a five-byte sequence, first byte at index 0
   function automatic logic [7:0] seqByte(input logic [39:0] seq,
                                          input logic [2:0]  idx);
      seqByte = seq[39 - 8 * idx -: 8];
   endfunction

   // Progress of a sequence after one written byte
   function automatic logic [2:0] seqStep(input logic [39:0] seq,
                                          input logic [2:0]  idx,
                                          input logic [7:0]  b);
      if (idx < SEQ_LEN && b == seqByte(seq, idx))
         seqStep = idx + 3'h1;
      else if (b == seqByte(seq, 3'h0))
         seqStep = 3'h1;
      else
         seqStep = 3'h0;
   endfunction

   // Number of 512-byte blocks held by the boot area
   function automatic logic [6:0] bootBlocks(input logic [1:0] sel);
      case (sel)
         2'h0:    bootBlocks = 7'h04;
         2'h1:    bootBlocks = 7'h08;
         2'h2:    bootBlocks = 7'h10;
         default: bootBlocks = 7'h00;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Combinational decode
   // ----------------------------------------------------------------
   logic [15:0]      fullAddr;
   logic [16:0]      infoAddr;
   logic             dataValid;
   logic             protect;
   logic [CNT_W-1:0] eraseLoad;
   logic             eraseOk;
   logic [4:0]       timField;

   // Address decode for operations and the erase duration
   always_comb
   begin
      fullAddr  = {st.addrHi, st.addrLo};
      timField  = st.tim[TIMING_FIELD-1:0];
      infoAddr  = INFO_BASE
                + {7'h00, st.addrHi[2], st.addrHi[0], st.addrLo};
      dataValid = (st.addrHi[6:2] == 5'h00);
      protect   = st.addrHi[7:1] < bootBlocks(bootSel);
      if (st.upgrade || st.areaSel)
      begin
         eraseOk   = (timField == TIMING_MAX);
         eraseLoad = CNT_W'(InfoCycles);
      end
      else
      begin
         eraseOk   = (timField >= TIMING_MIN) && (timField <= TIMING_MAX);
         eraseLoad = CNT_W'((32'(timField) + 1) * MsCycles
                   + ExtraCycles);
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st = st;

      // Operation timer; the CPU clock stays stopped until it expires
      if (st.op != OP_IDLE)
      begin
         if (st.cnt <= CNT_W'(1))
            next_st.op = OP_IDLE;
         else
            next_st.cnt = st.cnt - CNT_W'(1);
      end

      // Special-function register writes
      if (sfrWr)
      begin
         case (sfrAddr)
            SFR_ADDR_HIGH: next_st.addrHi = sfrWdata;
            SFR_ADDR_LOW:  next_st.addrLo = sfrWdata;
            SFR_WDATA:     next_st.wdata  = sfrWdata;
            SFR_TIMING:
               next_st.tim[TIMING_FIELD-1:0] = sfrWdata[TIMING_FIELD-1:0];
            SFR_COMMAND:
            begin
               next_st.cmd   = sfrWdata;
               next_st.enIdx = seqStep(SEQ_ENTER, st.enIdx, sfrWdata);
               next_st.exIdx = seqStep(SEQ_EXIT, st.exIdx, sfrWdata);
               // Strict order, restart on any stray byte
               if (next_st.enIdx == SEQ_LEN)
               begin
                  next_st.enIdx = 3'h0;
                  if (bootSel != BOOT_NONE && st.inBoot)
                     next_st.upgrade = 1'b1;
               end
               if (next_st.exIdx == SEQ_LEN)
               begin
                  next_st.exIdx   = 3'h0;
                  next_st.upgrade = 1'b0;
               end
               // New operations only while idle
               if (st.op == OP_IDLE)
               begin
                  if (sfrWdata == CMD_ERASE && eraseOk)
                  begin
                     if (st.upgrade)
                     begin
                        if (!protect)
                        begin
                           next_st.op     = OP_ERASE;
                           next_st.opAddr = {1'b0, st.addrHi[7:1],
                                             9'h000};
                        end
                     end
                     else if (st.areaSel)
                     begin
                        next_st.op     = OP_ERASE;
                        next_st.opAddr = {infoAddr[16:9], 9'h000};
                     end
                     else if (dataValid)
                     begin
                        next_st.op     = OP_ERASE;
                        next_st.opAddr = DATA_BASE;
                     end
                     next_st.cnt = eraseLoad;
                  end
                  else if (sfrWdata == CMD_PROG)
                  begin
                     next_st.opData = st.wdata;
                     next_st.cnt    = CNT_W'(PROG_CYCLES);
                     if (st.upgrade)
                     begin
                        if (!protect)
                        begin
                           next_st.op     = OP_PROG;
                           next_st.opAddr = {1'b0, fullAddr};
                        end
                     end
                     else if (st.areaSel)
                     begin
                        next_st.op     = OP_PROG;
                        next_st.opAddr = infoAddr;
                     end
                     else if (dataValid)
                     begin
                        next_st.op     = OP_PROG;
                        next_st.opAddr = DATA_BASE
                                       + {7'h00, fullAddr[9:0]};
                     end
                  end
                  // Any other value starts nothing
               end
            end
            default: ;
         endcase
      end

      // Secondary-bus register writes
      if (xbusWr)
      begin
         case (xbusAddr)
            XB_AREA_SELECT: next_st.areaSel = xbusWdata[0];
            XB_JUMP:
            begin
               next_st.jump    = xbusWdata;
               next_st.appIdx  = seqStep(SEQ_APP, st.appIdx, xbusWdata);
               next_st.bootIdx = seqStep(SEQ_BOOT, st.bootIdx, xbusWdata);
               if (next_st.appIdx == SEQ_LEN)
               begin
                  next_st.appIdx = 3'h0;
                  if (bootSel != BOOT_NONE)
                     next_st.inBoot = 1'b0;
               end
               if (next_st.bootIdx == SEQ_LEN)
               begin
                  next_st.bootIdx = 3'h0;
                  if (bootSel != BOOT_NONE)
                     next_st.inBoot = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // Operation strobes kept in flops so the outputs need no decode
      next_st.erase = (next_st.op == OP_ERASE);
      next_st.prog  = (next_st.op == OP_PROG);
      next_st.halt  = (next_st.op != OP_IDLE);

      // Code offset follows the execution space
      if (bootSel == BOOT_NONE || st.inBoot)
         next_st.offset = 16'h0000;
      else
      begin
         case (bootSel)
            2'h0:    next_st.offset = OFFSET_2K;
            2'h1:    next_st.offset = OFFSET_4K;
            default: next_st.offset = OFFSET_8K;
         endcase
      end

      // Flash read address: indirect reads or direct code reads
      if (st.cmd == CMD_READ && !st.upgrade)
      begin
         case (st.addrHi[7:6])
            2'b01:   next_st.rdAddr = {INFO_READ, fullAddr[11:0]};
            2'b10:   next_st.rdAddr = {1'b1, fullAddr};
            default: next_st.rdAddr = st.rdAddr;
         endcase
         next_st.rdData = flashRdata;
      end
      else
      begin
         next_st.rdAddr   = {1'b0, codeAddr};
         next_st.codeData = flashRdata;
      end

      // Register read data, unmapped offsets read zero
      if (sfrRd)
      begin
         case (sfrAddr)
            SFR_ADDR_HIGH: next_st.sfrOut = st.addrHi;
            SFR_ADDR_LOW:  next_st.sfrOut = st.addrLo;
            SFR_WDATA:     next_st.sfrOut = st.wdata;
            SFR_COMMAND:   next_st.sfrOut = st.cmd;
            SFR_TIMING:    next_st.sfrOut = st.tim;
            SFR_READ_DATA: next_st.sfrOut = st.rdData;
            default:       next_st.sfrOut = 8'h00;
         endcase
      end
      if (xbusRd)
      begin
         case (xbusAddr)
            XB_UPGRADE:     next_st.xbusOut = {7'h00, st.upgrade};
            XB_AREA_SELECT: next_st.xbusOut = {7'h00, st.areaSel};
            XB_JUMP:        next_st.xbusOut = st.jump;
            XB_OFFSET_LOW:  next_st.xbusOut = st.offset[7:0];
            XB_OFFSET_HIGH: next_st.xbusOut = st.offset[15:8];
            default:        next_st.xbusOut = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st        <= '0;
         st.tim    <= TIMING_RESET;
         st.inBoot <= 1'b1;
         st.op     <= OP_IDLE;
      end
      else
         st <= next_st;
   end

   // Outputs straight from the state flops
   assign sfrRdata    = st.sfrOut;
   assign xbusRdata   = st.xbusOut;
   assign codeRdata   = st.codeData;
   assign flashRdAddr = st.rdAddr;
   assign flashOpAddr = st.opAddr;
   assign flashOpData = st.opData;
   assign flashErase  = st.erase;
   assign flashProg   = st.prog;
   assign cpuClkHalt  = st.halt;
   assign upgradeMode = st.upgrade;

endmodule

// ==== src/fdais_pkg.sv ====
// Constants for the flash data-area and in-application upgrade sequencer.
// Assumes one 100 MHz clock and 8-bit register ports.
package fdais_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] SFR_ADDR_HIGH  = 8'h00ce;
   localparam logic [7:0] SFR_ADDR_LOW   = 8'h00cf;
   localparam logic [7:0] SFR_WDATA      = 8'h00d1;
   localparam logic [7:0] SFR_COMMAND    = 8'h00d2;
   localparam logic [7:0] SFR_TIMING     = 8'h00d3;
   localparam logic [7:0] SFR_READ_DATA  = 8'h00d4;
   localparam logic [7:0] XB_UPGRADE     = 8'h005a;
   localparam logic [7:0] XB_AREA_SELECT = 8'h005b;
   localparam logic [7:0] XB_JUMP        = 8'h006a;
   localparam logic [7:0] XB_OFFSET_LOW  = 8'h006b;
   localparam logic [7:0] XB_OFFSET_HIGH = 8'h006c;

   // ----------------------------------------------------------------
   // Reset values and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] TIMING_RESET  = 8'h00dd;
   localparam int         TIMING_FIELD  = 5;
   localparam logic [4:0] TIMING_MIN    = 5'h04;
   localparam logic [4:0] TIMING_MAX    = 5'h09;
   localparam logic [1:0] BOOT_NONE     = 2'h3;

   // ----------------------------------------------------------------
   // Command codes and five-byte sequences, first byte at the top
   // ----------------------------------------------------------------
   localparam logic [7:0]  CMD_ERASE  = 8'h0096;
   localparam logic [7:0]  CMD_PROG   = 8'h0069;
   localparam logic [7:0]  CMD_READ   = 8'h0088;
   localparam logic [39:0] SEQ_ENTER  = 40'h12_3456_789a;
   localparam logic [39:0] SEQ_EXIT   = 40'hfe_dcba_9876;
   localparam logic [39:0] SEQ_APP    = 40'hff_0088_55aa;
   localparam logic [39:0] SEQ_BOOT   = 40'h37_c842_9a65;
   localparam logic [2:0]  SEQ_LEN    = 3'h5;

   // ----------------------------------------------------------------
   // Physical map
   // ----------------------------------------------------------------
   localparam logic [16:0] DATA_BASE   = 17'h0_fc00;
   localparam logic [16:0] INFO_BASE   = 17'h1_0400;
   localparam logic [4:0]  INFO_READ   = 5'h10;
   localparam logic [15:0] OFFSET_2K   = 16'h0800;
   localparam logic [15:0] OFFSET_4K   = 16'h1000;
   localparam logic [15:0] OFFSET_8K   = 16'h2000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ          = 100;
   localparam int PROG_TIME_NS     = 23500;
   localparam int MS_TIME_NS       = 1000000;
   localparam int ERASE_EXTRA_NS   = 130000;
   localparam int INFO_ERASE_NS    = 4630000;
   localparam int PROG_CYCLES      = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int MS_CYCLES        = (MS_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int EXTRA_CYCLES     = (ERASE_EXTRA_NS * CLK_MHZ + 999) / 1000;
   localparam int INFO_CYCLES      = (INFO_ERASE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W            = 24;

   typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROG} fdais_op_e;

endpackage

// ==== dv/fdais_sva.sv ====
// Checker for the flash sequencer, watching its top-level ports.
// Assumes a bind from the bench top file.
`timescale 1ns/100ps
module fdais_sva
import fdais_pkg::*;
#(
   parameter int MsCycles    = MS_CYCLES,
   parameter int ExtraCycles = EXTRA_CYCLES,
   parameter int InfoCycles  = INFO_CYCLES
)
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       sfrWr,
   input wire logic       sfrRd,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWdata,
   input wire logic [7:0] sfrRdata,
   input wire logic       xbusWr,
   input wire logic [7:0] xbusAddr,
   input wire logic [7:0] xbusWdata,
   input wire logic [1:0] bootSel,
   input wire logic [7:0] flashOpData,
   input wire logic       flashErase,
   input wire logic       flashProg,
   input wire logic       cpuClkHalt,
   input wire logic       upgradeMode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [4:0] tim;
   logic       area;
   logic [7:0] wdat;
   int         eLen;
   int         eCnt;
   int         pCnt;
   wire        cmdW = sfrWr && sfrAddr == SFR_COMMAND;
   // ---------------------------------------------
   // Shadow registers and run-length counters
   // ---------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tim  <= TIMING_RESET[4:0];
         area <= 1'b0;
         wdat <= 8'h00;
         eLen <= 0;
         eCnt <= 0;
         pCnt <= 0;
      end
      else
      begin
         if (sfrWr && sfrAddr == SFR_TIMING)
            tim <= sfrWdata[4:0];
         if (xbusWr && xbusAddr == XB_AREA_SELECT)
            area <= xbusWdata[0];
         if (sfrWr && sfrAddr == SFR_WDATA)
            wdat <= sfrWdata;
         if (cmdW && sfrWdata == CMD_ERASE && !cpuClkHalt)
            eLen <= (area || upgradeMode) ? InfoCycles
                    : (int'(tim) + 1) * MsCycles + ExtraCycles;
         eCnt <= flashErase ? eCnt + 1 : 0;
         pCnt <= flashProg ? pCnt + 1 : 0;
      end
   end
   a_halt_follows_op: assert property (
      cpuClkHalt == (flashErase || flashProg))
      else $error("halt does not follow the running operation");
   a_op_exclusive: assert property (
      !(flashErase && flashProg))
      else $error("erase and program run together");
   a_erase_cause: assert property (
      $rose(flashErase) |-> $past(cmdW && sfrWdata == CMD_ERASE))
      else $error("erase started without its command");
   a_prog_cause: assert property (
      $rose(flashProg) |-> $past(cmdW && sfrWdata == CMD_PROG)
         && flashOpData == wdat)
      else $error("program started wrongly");
   a_erase_length: assert property (
      $fell(flashErase) |-> eCnt == eLen)
      else $error("erase length wrong");
   a_prog_length: assert property (
      $fell(flashProg) |-> pCnt == PROG_CYCLES)
      else $error("program length wrong");
   a_enter_cause: assert property (
      $rose(upgradeMode) |-> $past(cmdW && sfrWdata == 8'h9a)
         && bootSel != BOOT_NONE)
      else $error("upgrade mode entered wrongly");
   a_exit_cause: assert property (
      $fell(upgradeMode) |-> $past(cmdW && sfrWdata == 8'h76))
      else $error("upgrade mode left wrongly");
   a_no_boot_entry: assert property (
      bootSel == BOOT_NONE && !upgradeMode |=> !upgradeMode)
      else $error("upgrade entered without boot area");
   a_timing_read: assert property (
      sfrRd && sfrAddr == SFR_TIMING |=> sfrRdata == {3'b110, tim})
      else $error("timing register reads wrong");
endmodule

// ==== dv/fdais_flash.sv ====
// Flash array model standing behind the sequencer.
// Assumes registered operation controls from the sequencer.
`timescale 1ns/100ps
module fdais_flash
(
   input  wire logic        clk,
   input  wire logic [16:0] flashRdAddr,
   input  wire logic [16:0] flashOpAddr,
   input  wire logic [7:0]  flashOpData,
   input  wire logic        flashErase,
   input  wire logic        flashProg,
   output      logic [7:0]  flashRdata
);
   logic [7:0] mem [0:131071];
   bit         eraseSeen;
   bit         progSeen;
   int         size;
   // Array starts erased
   initial
      foreach (mem[i])
         mem[i] = 8'hff;
   // Erase sets a page to ones; program can only clear bits
   always @(posedge clk)
   begin
      if (flashErase && !eraseSeen)
      begin
         size = (flashOpAddr >= 17'h0_fc00 && flashOpAddr < 17'h1_0000)
                ? 1024 : 512;
         for (int i = 0; i < size; i++)
            mem[flashOpAddr + i] = 8'hff;
      end
      if (flashProg && !progSeen)
         mem[flashOpAddr] = mem[flashOpAddr] & flashOpData;
      eraseSeen = flashErase;
      progSeen = flashProg;
   end
   // Read data follows the address in the same cycle
   assign flashRdata = mem[flashRdAddr];
endmodule

// ==== dv/fdais_sequencer_bench.sv ====
// Directed bench for the flash sequencer over its register ports.
// Assumes the package, design, flash model and checker compile first.
`timescale 1ns/100ps
module fdais_sequencer_bench;
   import fdais_pkg::*;
   localparam int Ms  = 10;
   localparam int Ex  = 3;
   localparam int Inf = 20;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sfrWr = 1'b0;
   logic        sfrRd = 1'b0;
   logic        xbusWr = 1'b0;
   logic        xbusRd = 1'b0;
   logic [7:0]  sfrAddr = 8'h00;
   logic [7:0]  sfrWdata = 8'h00;
   logic [7:0]  xbusAddr = 8'h00;
   logic [7:0]  xbusWdata = 8'h00;
   logic [1:0]  bootSel = 2'h0;
   logic [15:0] codeAddr = 16'h0000;
   logic [7:0]  sfrRdata, xbusRdata, codeRdata, flashRdata, flashOpData;
   logic [16:0] flashRdAddr, flashOpAddr;
   logic        flashErase, flashProg, cpuClkHalt, upgradeMode;
   int          fail_count = 0;
   int          checks_done = 0;
   fdais_sequencer #(.MsCycles(Ms), .ExtraCycles(Ex), .InfoCycles(Inf))
      u_fdais_sequencer (.*);
   fdais_flash u_fdais_flash (.*);
   // ---------------------------------------------
   // Clock, tasks and tests
   // ---------------------------------------------
   always #5 clk = ~clk;
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(string nm, logic [16:0] e, logic [16:0] g);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(bit xb, logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      #1;
      {sfrAddr, xbusAddr, sfrWdata, xbusWdata} = {a, a, d, d};
      {sfrWr, xbusWr} = {!xb, xb};
      @(posedge clk);
      #1;
      {sfrWr, xbusWr} = 2'b00;
   endtask
   task automatic rd(bit xb, logic [7:0] a, logic [7:0] e, string nm);
      repeat (2) @(posedge clk);
      #1;
      {sfrAddr, xbusAddr, sfrRd, xbusRd} = {a, a, !xb, xb};
      @(posedge clk);
      #1;
      {sfrRd, xbusRd} = 2'b00;
      @(posedge clk);
      #1;
      check(nm, e, xb ? xbusRdata : sfrRdata);
   endtask
   task automatic seq(bit xb, logic [39:0] s);
      for (int i = 4; i >= 0; i--)
         wr(xb, xb ? XB_JUMP : SFR_COMMAND, s[i*8 +: 8]);
   endtask
   task automatic op(logic [7:0] c, int len, logic [16:0] ad, string nm);
      int n = 0;
      wr(0, SFR_COMMAND, c);
      for (int i = 0; i < len + 20; i++)
      begin
         if (cpuClkHalt !== 1'b1 && n > 0)
            break;
         if (cpuClkHalt === 1'b1 && n == 0)
            check({nm, " addr"}, ad, flashOpAddr);
         n += (cpuClkHalt === 1'b1);
         @(posedge clk);
         #1;
      end
      check(nm, len, n);
      $display("test %s done", nm);
   endtask
   task automatic cr(logic [15:0] a, logic [7:0] e);
      codeAddr = a;
      repeat (3) @(posedge clk);
      #1;
      check("code read", e, codeRdata);
   endtask
   // Watchdog sized well above the expected run length
   initial
   begin
      #600000;
      fail_count++;
      test_done();
   end
   // Main test sequence
   initial
   begin
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      rd(0, SFR_TIMING, 8'hdd, "timing reset");
      rd(1, XB_UPGRADE, 8'h00, "upgrade reset");
      rd(1, XB_OFFSET_LOW, 8'h00, "offset low");
      rd(1, XB_JUMP, 8'h00, "jump reset");
      rd(0, 8'h10, 8'h00, "unmapped");
      wr(1, XB_OFFSET_HIGH, 8'h55);
      rd(1, XB_OFFSET_HIGH, 8'h00, "offset ro");
      wr(0, SFR_TIMING, 8'h04);
      op(CMD_ERASE, 5 * Ms + Ex, DATA_BASE, "erase data");
      wr(0, SFR_ADDR_HIGH, 8'h01);
      wr(0, SFR_ADDR_LOW, 8'h23);
      wr(0, SFR_WDATA, 8'h5a);
      op(CMD_PROG, PROG_CYCLES, 17'h0_fd23, "prog data");
      cr(16'hfd23, 8'h5a);
      cr(16'hfd24, 8'hff);
      op(8'h55, 0, 17'h0_0000, "odd cmd");
      wr(0, SFR_TIMING, 8'h03);
      op(CMD_ERASE, 0, 17'h0_0000, "reserved timing");
      wr(0, SFR_TIMING, 8'h04);
      wr(0, SFR_ADDR_LOW, 8'h24);
      wr(0, SFR_COMMAND, CMD_PROG);
      op(CMD_ERASE, PROG_CYCLES - 2, 17'h0_fd24, "busy");
      wr(1, XB_AREA_SELECT, 8'h01);
      op(CMD_ERASE, 0, 17'h0_0000, "info timing");
      wr(0, SFR_TIMING, 8'h09);
      wr(0, SFR_ADDR_HIGH, 8'h46);
      wr(0, SFR_ADDR_LOW, 8'h00);
      op(CMD_ERASE, Inf, 17'h1_0600, "erase info");
      wr(0, SFR_ADDR_LOW, 8'h05);
      wr(0, SFR_WDATA, 8'h3c);
      op(CMD_PROG, PROG_CYCLES, 17'h1_0605, "prog info");
      wr(0, SFR_COMMAND, CMD_READ);
      rd(0, SFR_READ_DATA, 8'h3c, "indirect");
      wr(0, SFR_ADDR_LOW, 8'h06);
      rd(0, SFR_READ_DATA, 8'hff, "indirect erased");
      wr(0, SFR_ADDR_HIGH, 8'h80);
      rd(0, SFR_READ_DATA, 8'hff, "system block");
      check("system addr", 17'h1_8006, flashRdAddr);
      wr(0, SFR_ADDR_HIGH, 8'h40);
      op(CMD_PROG, PROG_CYCLES, 17'h1_0406, "prog page0");
      wr(0, SFR_COMMAND, 8'h00);
      wr(0, SFR_ADDR_HIGH, 8'h00);
      wr(0, SFR_ADDR_LOW, 8'h00);
      wr(1, XB_AREA_SELECT, 8'h00);
      seq(0, 40'h12_3400_789a);
      rd(1, XB_UPGRADE, 8'h00, "broken sequence");
      seq(0, SEQ_ENTER);
      rd(1, XB_UPGRADE, 8'h01, "enter");
      wr(0, SFR_ADDR_HIGH, 8'h06);
      op(CMD_ERASE, 0, 17'h0_0000, "boot protect");
      wr(0, SFR_ADDR_HIGH, 8'h08);
      op(CMD_ERASE, Inf, 17'h0_0800, "erase block");
      wr(0, SFR_ADDR_LOW, 8'h01);
      wr(0, SFR_WDATA, 8'h77);
      op(CMD_PROG, PROG_CYCLES, 17'h0_0801, "prog block");
      cr(16'h0801, 8'h77);
      seq(0, SEQ_EXIT);
      rd(1, XB_UPGRADE, 8'h00, "exit");
      for (int b = 0; b < 4; b++)
      begin
         bootSel = b[1:0];
         seq(1, SEQ_APP);
         rd(1, XB_JUMP, 8'haa, "jump last");
         rd(1, XB_OFFSET_HIGH, b < 3 ? 8'h08 << b : 8'h00, "app");
         seq(0, SEQ_ENTER);
         rd(1, XB_UPGRADE, 8'h00, "enter refused");
         seq(1, SEQ_BOOT);
         rd(1, XB_OFFSET_HIGH, 8'h00, "boot offset");
      end
      $display("test spaces done");
      test_done();
   end
endmodule
bind fdais_sequencer fdais_sva
   #(.MsCycles(MsCycles), .ExtraCycles(ExtraCycles),
     .InfoCycles(InfoCycles))
   u_fdais_sva (.clk(clk), .rst_n(rst_n), .sfrWr(sfrWr), .sfrRd(sfrRd),
      .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
      .xbusWr(xbusWr), .xbusAddr(xbusAddr), .xbusWdata(xbusWdata),
      .bootSel(bootSel), .flashOpData(flashOpData),
      .flashErase(flashErase), .flashProg(flashProg),
      .cpuClkHalt(cpuClkHalt), .upgradeMode(upgradeMode));
